// ===== pkg/touch_regs.svh
// Constants for the touch detect and stream block
`ifndef TOUCH_REGS_SVH
`define TOUCH_REGS_SVH
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define COUNTS_OFFSET 8'h08
`define BITPER_OFFSET 8'h0C
`define CFG_WIDTH 11
`define CFG_RESET 11'h400
`define CFG_TSEL_LSB 0
`define CFG_PSEL_LSB 3
`define CFG_HALT_LSB 5
`define CFG_STREAM_BIT 7
`define CFG_SHORT_BIT 8
`define CFG_CTRL_OUT_BIT 9
`define CFG_ACT_HIGH_BIT 10
`define STATUS_FAULT_BIT 3
`define BITPER_RESET 16'h0064
`define START_CYC_RESET 16'h00C8
`define TOUCH_CONFIRM 2'h2
`define PROX_CONFIRM 3'h6
`define REL_SHIFT 1
`define FILT_SHIFT 4
`define SYNC_BYTE 8'hAA
`define BYTES_SHORT 4'h5
`define BYTES_LONG 4'h8
`define CLK_HZ 64'd250000000
`define HALT_A_S 64'd18
`define HALT_B_S 64'd60
`define HALT_C_S 64'd3
`endif

// ===== pkg/touch_pkg.sv
// Types shared by the touch detect and stream block
package touch_pkg;
  typedef logic [15:0] count_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_LEAD = 5'h02,
    TX_SBIT = 5'h04,
    TX_DATA = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;
endpackage : touch_pkg

// ===== verilog/stream_tx.sv
// One-wire frame transmitter for the debug stream
`timescale 1ns/1ps
`include "touch_regs.svh"
module stream_tx import touch_pkg::*; #(
  parameter logic [15:0] START_CYC = `START_CYC_RESET
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame request
  input wire logic start,
  input wire logic long_frame,
  input wire logic [63:0] frame,
  input wire logic [15:0] bit_period,
  // Line
  output logic line,
  output logic busy
);
  tx_state_t state_reg;
  logic [15:0] timer_reg;
  logic [2:0] bit_reg;
  logic [3:0] byte_reg;
  logic [3:0] last_reg;
  logic [7:0] shift_reg;
  logic [63:0] frame_reg;
  logic bit_done;
  logic lead_done;

  assign bit_done = (timer_reg == 16'(bit_period - 16'h0001));
  assign lead_done = (timer_reg == 16'(START_CYC - 16'h0001));

  //////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TX_IDLE;
      timer_reg <= 16'h0000;
      bit_reg <= 3'h0;
      byte_reg <= 4'h0;
      last_reg <= 4'h0;
      shift_reg <= 8'h00;
      frame_reg <= 64'h0;
      line <= 1'b1;
      busy <= 1'b0;
    end else begin
      timer_reg <= 16'(timer_reg + 16'h0001);
      unique case (state_reg)
        TX_IDLE: begin
          timer_reg <= 16'h0000;
          if (start) begin
            frame_reg <= frame;
            last_reg <= long_frame ? `BYTES_LONG : `BYTES_SHORT;
            byte_reg <= 4'h0;
            shift_reg <= `SYNC_BYTE;
            line <= 1'b0;
            busy <= 1'b1;
            state_reg <= TX_LEAD;
          end
        end
        TX_LEAD: if (lead_done) begin
          timer_reg <= 16'h0000;
          state_reg <= TX_SBIT;
        end
        TX_SBIT: if (bit_done) begin
          timer_reg <= 16'h0000;
          bit_reg <= 3'h0;
          line <= shift_reg[7];
          state_reg <= TX_DATA;
        end
        TX_DATA: if (bit_done) begin
          timer_reg <= 16'h0000;
          if (bit_reg == 3'h7) begin
            line <= 1'b1;
            state_reg <= TX_STOP;
          end else begin
            bit_reg <= 3'(bit_reg + 3'h1);
            shift_reg <= {shift_reg[6:0], 1'b0};
            line <= shift_reg[6];
          end
        end
        TX_STOP: if (bit_done) begin
          timer_reg <= 16'h0000;
          if (byte_reg == last_reg) begin
            busy <= 1'b0;
            state_reg <= TX_IDLE;
          end else begin
            shift_reg <= frame_reg[{byte_reg[2:0], 3'h0} +: 8];
            byte_reg <= 4'(byte_reg + 4'h1);
            line <= 1'b0;
            state_reg <= TX_SBIT;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  lead_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TX_LEAD) |-> !line)
    else $error("line not low during lead start");
  stop_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TX_DATA && bit_done && bit_reg == 3'h7) |=> line)
    else $error("stop bit not high");
endmodule : stream_tx

// ===== verilog/touch_detect.sv
// Touch and proximity detection with debug stream and APB registers
`timescale 1ns/1ps
`include "touch_regs.svh"
module touch_detect import touch_pkg::*; #(
  parameter logic [35:0] HALT_A_CYC = 36'(`HALT_A_S * `CLK_HZ),
  parameter logic [35:0] HALT_B_CYC = 36'(`HALT_B_S * `CLK_HZ),
  parameter logic [35:0] HALT_C_CYC = 36'(`HALT_C_S * `CLK_HZ),
  parameter logic [15:0] START_CYC = `START_CYC_RESET
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement side
  input wire logic sample_valid,
  input wire count_t sensor_count,
  input wire logic auto_tuning_busy,
  input wire logic zoom_active,
  input wire logic [2:0] tuning_multiplier,
  input wire logic [5:0] tuning_compensation,
  // Control pin
  input wire logic ctrl_in,
  output logic ctrl_out,
  output logic ctrl_oe_n,
  // Output pin
  output logic out_pin_out,
  output logic out_pin_oe_n
);
  //////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`CFG_WIDTH-1:0] cfg_reg;
  logic [15:0] bit_period_reg;
  logic fault_flag_reg;
  logic [2:0] tsel;
  logic [1:0] psel_thr;
  logic [1:0] halt_sel;
  logic stream_en;
  logic short_en;
  logic ctrl_dir_out;
  logic active_high;
  logic [8:0] touch_threshold;
  logic [8:0] release_threshold;
  logic [8:0] proximity_threshold;
  count_t long_term_average;
  logic seeded_reg;
  logic touch_reg;
  logic prox_reg;
  logic [1:0] touch_cnt_reg;
  logic [2:0] prox_cnt_reg;
  logic signed [16:0] diff;
  logic signed [16:0] below;
  logic signed [16:0] lta_sum;
  logic below_hit;
  logic above_rel;
  logic prox_hit;
  logic run;
  logic touch_enter;
  logic filter_run;
  logic ctrl_meta_reg;
  logic ctrl_sync_reg;
  logic ctrl_hold;
  logic [35:0] halt_cnt_reg;
  logic [35:0] halt_limit;
  logic fault;
  logic out_state;
  logic out_level;
  logic stream_go_reg;
  logic [7:0] frame_cnt_reg;
  logic [63:0] frame;
  logic tx_line;
  logic tx_busy;
  logic setup;
  logic access;
  logic addr_hit;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////
  // Configuration fields
  assign tsel = cfg_reg[`CFG_TSEL_LSB +: 3];
  assign psel_thr = cfg_reg[`CFG_PSEL_LSB +: 2];
  assign halt_sel = cfg_reg[`CFG_HALT_LSB +: 2];
  assign stream_en = cfg_reg[`CFG_STREAM_BIT];
  assign short_en = cfg_reg[`CFG_SHORT_BIT];
  assign ctrl_dir_out = cfg_reg[`CFG_CTRL_OUT_BIT];
  assign active_high = cfg_reg[`CFG_ACT_HIGH_BIT];

  // Threshold tables
  always_comb begin
    unique case (tsel)
      3'h0: touch_threshold = 9'h010;
      3'h1: touch_threshold = 9'h028;
      3'h2: touch_threshold = 9'h03C;
      3'h3: touch_threshold = 9'h05A;
      3'h4: touch_threshold = 9'h082;
      3'h5: touch_threshold = 9'h0C8;
      3'h6: touch_threshold = 9'h154;
      3'h7: touch_threshold = 9'h1F4;
    endcase
  end

  always_comb begin
    unique case (psel_thr)
      2'h0: proximity_threshold = 9'h004;
      2'h1: proximity_threshold = 9'h008;
      2'h2: proximity_threshold = 9'h00C;
      2'h3: proximity_threshold = 9'h010;
    endcase
  end

  assign release_threshold = touch_threshold >> `REL_SHIFT;

  always_comb begin
    unique case (halt_sel)
      2'h0: halt_limit = 36'h0;
      2'h1: halt_limit = HALT_A_CYC;
      2'h2: halt_limit = HALT_B_CYC;
      2'h3: halt_limit = HALT_C_CYC;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Comparisons
  assign diff = $signed({1'b0, sensor_count}) - $signed({1'b0, long_term_average});
  assign below = $signed({1'b0, long_term_average}) - $signed({1'b0, sensor_count});
  assign below_hit = below > $signed({8'h00, touch_threshold});
  assign above_rel = diff >= $signed({8'h00, release_threshold});
  assign prox_hit = (diff > $signed({8'h00, proximity_threshold}))
    || (below > $signed({8'h00, proximity_threshold}));
  assign run = sample_valid && seeded_reg && !fault && !auto_tuning_busy;
  assign touch_enter = run && !touch_reg && below_hit
    && (touch_cnt_reg == 2'(`TOUCH_CONFIRM - 2'h1));
  assign ctrl_hold = !ctrl_dir_out && ctrl_sync_reg;
  assign filter_run = (!prox_reg || touch_reg) && !ctrl_hold;
  assign lta_sum = $signed({1'b0, long_term_average}) + (diff >>> `FILT_SHIFT);

  //////////////////////////////////////////////////////////////////////
  // Control pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_meta_reg <= 1'b0;
      ctrl_sync_reg <= 1'b0;
    end else begin
      ctrl_meta_reg <= ctrl_in;
      ctrl_sync_reg <= ctrl_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Touch state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_reg <= 1'b0;
      touch_cnt_reg <= 2'h0;
    end else if (fault) begin
      touch_reg <= 1'b0;
      touch_cnt_reg <= 2'h0;
    end else if (run) begin
      if (!touch_reg) begin
        if (touch_enter) begin
          touch_reg <= 1'b1;
          touch_cnt_reg <= 2'h0;
        end else if (below_hit) begin
          touch_cnt_reg <= 2'(touch_cnt_reg + 2'h1);
        end else begin
          touch_cnt_reg <= 2'h0;
        end
      end else if (above_rel) begin
        touch_reg <= 1'b0;
      end
    end
  end

  // Proximity state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prox_reg <= 1'b0;
      prox_cnt_reg <= 3'h0;
    end else if (fault) begin
      prox_reg <= 1'b0;
      prox_cnt_reg <= 3'h0;
    end else if (run) begin
      if (!prox_hit) begin
        prox_reg <= 1'b0;
        prox_cnt_reg <= 3'h0;
      end else if (prox_cnt_reg == 3'(`PROX_CONFIRM - 3'h1)) begin
        prox_reg <= 1'b1;
      end else begin
        prox_cnt_reg <= 3'(prox_cnt_reg + 3'h1);
      end
    end
  end

  // Long-term average
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_term_average <= 16'h0000;
      seeded_reg <= 1'b0;
    end else if (fault || (sample_valid && !seeded_reg)) begin
      long_term_average <= sensor_count;
      seeded_reg <= 1'b1;
    end else if (touch_enter) begin
      long_term_average <= (long_term_average < {7'h00, touch_threshold}) ? 16'h0000
        : 16'(long_term_average - {7'h00, touch_threshold});
    end else if (run && filter_run) begin
      long_term_average <= lta_sum[15:0];
    end
  end

  // Freeze timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_reg <= 36'h0;
    end else if (prox_reg && !touch_reg && !ctrl_hold && !fault) begin
      halt_cnt_reg <= 36'(halt_cnt_reg + 36'h1);
    end else begin
      halt_cnt_reg <= 36'h0;
    end
  end

  assign fault = (halt_sel != 2'h0) && (halt_cnt_reg >= halt_limit);

  //////////////////////////////////////////////////////////////////////
  // Pins
  assign out_state = prox_reg || touch_reg;
  assign out_level = active_high ? out_state : !out_state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin_out <= 1'b1;
      out_pin_oe_n <= 1'b1;
      ctrl_out <= 1'b0;
      ctrl_oe_n <= 1'b1;
    end else begin
      out_pin_out <= stream_en ? tx_line : out_level;
      out_pin_oe_n <= active_high ? 1'b0 : (stream_en ? tx_line : out_level);
      ctrl_out <= out_level;
      ctrl_oe_n <= !ctrl_dir_out;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Stream launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_go_reg <= 1'b0;
      frame_cnt_reg <= 8'h00;
    end else begin
      stream_go_reg <= sample_valid && stream_en && !tx_busy;
      if (stream_go_reg) begin
        frame_cnt_reg <= 8'(frame_cnt_reg + 8'h01);
      end
    end
  end

  assign frame = {frame_cnt_reg,
    2'b00, tuning_compensation[5], tsel, psel_thr,
    tuning_multiplier, tuning_compensation[4:0],
    auto_tuning_busy, prox_reg, touch_reg, out_state, 1'b0, zoom_active, 2'b00,
    long_term_average[7:0], long_term_average[15:8],
    sensor_count[7:0], sensor_count[15:8]};

  stream_tx #(
    .START_CYC(START_CYC)
  ) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .start(stream_go_reg),
    .long_frame(!short_en),
    .frame(frame),
    .bit_period(bit_period_reg),
    .line(tx_line),
    .busy(tx_busy)
  );

  //////////////////////////////////////////////////////////////////////
  // APB slave
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign addr_hit = (paddr == `CFG_OFFSET) || (paddr == `STATUS_OFFSET)
    || (paddr == `COUNTS_OFFSET) || (paddr == `BITPER_OFFSET);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `CFG_OFFSET: rd_mux = {21'h0, cfg_reg};
      `STATUS_OFFSET: rd_mux = {26'h0, tx_busy, seeded_reg, fault_flag_reg,
        out_state, touch_reg, prox_reg};
      `COUNTS_OFFSET: rd_mux = {long_term_average, sensor_count};
      `BITPER_OFFSET: rd_mux = {16'h0, bit_period_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !addr_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CFG_RESET;
      bit_period_reg <= `BITPER_RESET;
    end else if (access && pwrite) begin
      if (paddr == `CFG_OFFSET) begin
        cfg_reg <= pwdata[`CFG_WIDTH-1:0];
      end
      if (paddr == `BITPER_OFFSET) begin
        bit_period_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // Sticky fault flag, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_reg <= 1'b0;
    end else if (fault) begin
      fault_flag_reg <= 1'b1;
    end else if (access && pwrite && paddr == `STATUS_OFFSET
        && pwdata[`STATUS_FAULT_BIT]) begin
      fault_flag_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  thr_table_a: assert property ((tsel == 3'h6) |-> touch_threshold == 9'h154)
    else $error("touch threshold mapping wrong");
  touch_confirm_a: assert property ($rose(touch_reg) |->
    $past(touch_cnt_reg) == 2'h1 && $past(sample_valid) && $past(below_hit))
    else $error("touch entered without two samples");
  touch_reload_a: assert property ($rose(touch_reg)
    && $past(long_term_average) >= {7'h00, $past(touch_threshold)}
    |-> long_term_average == 16'($past(long_term_average) - {7'h00, $past(touch_threshold)}))
    else $error("average not reloaded on touch");
  release_a: assert property (touch_reg && run && above_rel |=> !touch_reg)
    else $error("release not taken");
  prox_confirm_a: assert property ($rose(prox_reg) |->
    $past(prox_cnt_reg) == 3'h5 && $past(prox_hit))
    else $error("proximity entered early");
  lta_freeze_a: assert property (prox_reg && !touch_reg && !fault && seeded_reg
    && !touch_enter |=> $stable(long_term_average))
    else $error("average moved during proximity");
  ctrl_follow_a: assert property (ctrl_dir_out && active_high && out_state
    |=> !ctrl_oe_n && ctrl_out)
    else $error("control output not asserted");
  fault_reseed_a: assert property (fault |=> !prox_reg && !touch_reg
    && long_term_average == $past(sensor_count))
    else $error("fault did not reseed");
  stream_line_a: assert property (stream_en |=> out_pin_out == $past(tx_line))
    else $error("output pin not carrying stream");
endmodule : touch_detect

// ===== test/stream_rx_model.sv
// Host side receiver model for the one-wire debug stream
`timescale 1ns/1ps
module stream_rx_model (
  // Clock and line
  input wire logic pclk,
  input wire logic line,
  input wire logic en
);
  logic [7:0] rx [0:8];
  int n_bytes = 0;
  int lead_len = 0;
  int bit_per = 0;
  int frames = 0;
  int c;
  int h;
  int i;
  ////////////////////////////////////////////////////////////////////////////////
  // Frame decoder, sampled mid-cycle
  initial begin
    forever begin
      @(negedge line iff en === 1'b1);
      c = 0;
      @(negedge pclk);
      while (line === 1'b0 && c < 5000) begin
        c++;
        @(negedge pclk);
      end
      h = 0;
      while (line === 1'b1 && h < 1000) begin
        h++;
        @(negedge pclk);
      end
      // Bit timing recovered from the sync byte
      bit_per = h;
      lead_len = c - h;
      rx[0] = 8'h80;
      repeat (h / 2) @(negedge pclk);
      for (i = 1; i < 8; i++) begin
        rx[0][7 - i] = line;
        repeat (h) @(negedge pclk);
      end
      n_bytes = 1;
      forever begin
        // Open-length stop: wait for next falling start edge
        c = 0;
        while (line === 1'b1 && c < 4 * h) begin
          c++;
          @(negedge pclk);
        end
        if (line === 1'b1 || n_bytes > 8) break;
        repeat (h / 2) @(negedge pclk);
        for (i = 0; i < 8; i++) begin
          repeat (h) @(negedge pclk);
          rx[n_bytes][7 - i] = line;
        end
        repeat (h) @(negedge pclk);
        n_bytes++;
      end
      frames++;
    end
  end
endmodule : stream_rx_model

// ===== test/capacitive_touch_detect_stream_tb_top.sv
// Testbench for the touch detect and stream block
`timescale 1ns/1ps
module capacitive_touch_detect_stream_tb_top import touch_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b0;
  count_t sensor_count = 16'h0000;
  logic ctrl_drv = 1'b0;
  logic rx_en = 1'b0;
  logic atb = 1'b0;
  logic zoom = 1'b1;
  logic [2:0] mult = 3'h5;
  logic [5:0] comp = 6'h2B;
  logic ctrl_out;
  logic ctrl_oe_n;
  logic out_pin_out;
  logic out_pin_oe_n;
  wire logic ctrl_wire;
  wire logic line;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] exp_b [0:7] = '{8'hAA, 8'h12, 8'h34, 8'h12, 8'h34, 8'h04, 8'hAB, 8'h39};
  // Wire levels: line pulled up when released, ctrl_wire takes ctrl_drv when released
  assign ctrl_wire = ctrl_oe_n ? ctrl_drv : ctrl_out;
  assign line = out_pin_oe_n ? 1'b1 : out_pin_out;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and host model
  touch_detect #(.HALT_A_CYC(36'd2000), .HALT_B_CYC(36'd4000), .HALT_C_CYC(36'd1000),
    .START_CYC(16'd20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sensor_count(sensor_count), .auto_tuning_busy(atb), .zoom_active(zoom),
    .tuning_multiplier(mult), .tuning_compensation(comp), .ctrl_in(ctrl_wire),
    .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n), .out_pin_out(out_pin_out),
    .out_pin_oe_n(out_pin_oe_n));
  stream_rx_model u_rx (.pclk(pclk), .line(line), .en(rx_en));
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset();
    rx_en <= 1'b0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, e, rd & m);
  endtask : chk_reg
  task automatic samp(input count_t c);
    sample_valid <= 1'b1;
    sensor_count <= c;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (15) @(posedge pclk);
  endtask : samp
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (u_rx.frames < n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk("frames", n, u_rx.frames);
  endtask : wait_frames
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_bus();
    logic [31:0] rd;
    logic err;
    chk_reg("cfg", 8'h00, 32'hFFFFFFFF, 32'h00000400);
    chk_reg("bitper", 8'h0C, 32'hFFFFFFFF, 32'h00000064);
    chk("ctrl_oe_n", 32'h1, 32'(ctrl_oe_n));
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk("unmapped", 32'h1, {rd[30:0], err});
  endtask : test_reset_bus
  task automatic test_detect();
    wr(8'h00, 32'h00000600);
    samp(16'd1000);
    chk("ctrl_oe_n out", 32'h0, 32'(ctrl_oe_n));
    repeat (5) samp(16'd1015);
    chk_reg("prox 5", 8'h04, 32'h3, 32'h0);
    samp(16'd1015);
    chk_reg("prox 6", 8'h04, 32'h7, 32'h5);
    chk("ctrl prox", 32'h1, 32'(ctrl_out));
    samp(16'd1100);
    chk_reg("avg frozen", 8'h08, 32'hFFFF0000, {16'd1000, 16'h0});
    samp(16'd980);
    chk_reg("touch 1", 8'h04, 32'h2, 32'h0);
    samp(16'd980);
    chk_reg("touch 2", 8'h04, 32'h2, 32'h2);
    chk_reg("avg reload", 8'h08, 32'hFFFF0000, {16'd984, 16'h0});
    samp(16'd900);
    chk_reg("avg track", 8'h08, 32'hFFFF0000, {16'd978, 16'h0});
    samp(16'd985);
    chk_reg("no release", 8'h04, 32'h2, 32'h2);
    chk("ctrl touch", 32'h1, 32'(ctrl_out));
    samp(16'd986);
    chk_reg("release", 8'h04, 32'h2, 32'h0);
  endtask : test_detect
  task automatic test_freeze();
    wr(8'h00, 32'h00000660);
    samp(16'd1000);
    repeat (6) samp(16'd1015);
    repeat (800) @(posedge pclk);
    chk_reg("prox held", 8'h04, 32'h9, 32'h1);
    repeat (300) @(posedge pclk);
    chk_reg("fault", 8'h04, 32'hF, 32'h8);
    chk_reg("reseed", 8'h08, 32'hFFFF0000, {16'd1015, 16'h0});
    chk("out idle", 32'h0, {30'h0, out_pin_out, ctrl_out});
  endtask : test_freeze
  task automatic test_stream();
    logic [7:0] cnt;
    int i;
    wr(8'h0C, 32'h00000008);
    wr(8'h00, 32'h0000048E);
    repeat (4) @(posedge pclk);
    chk("line idle", 32'h1, 32'(line));
    rx_en <= 1'b1;
    samp(16'h1234);
    wait_frames(1);
    cnt = u_rx.rx[8];
    samp(16'h1234);
    wait_frames(2);
    chk("lead", 32'd20, 32'(u_rx.lead_len));
    chk("period", 32'd8, 32'(u_rx.bit_per));
    chk("long n", 32'd9, 32'(u_rx.n_bytes));
    for (i = 0; i < 8; i++) begin
      chk("byte", 32'(exp_b[i]), 32'(u_rx.rx[i]));
    end
    chk("counter", 32'(8'(cnt + 8'h01)), 32'(u_rx.rx[8]));
    wr(8'h00, 32'h0000058E);
    samp(16'h1234);
    wait_frames(3);
    chk("short n", 32'd6, 32'(u_rx.n_bytes));
    chk("stop high", 32'h1, 32'(line));
  endtask : test_stream
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    do_reset();
    test_reset_bus();
    test_detect();
    do_reset();
    test_freeze();
    do_reset();
    test_stream();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
endmodule : capacitive_touch_detect_stream_tb_top
